// [rtl/event_counter_and_delay_timer.v]
// Operation
// - count source: off, frame, row, exposure, host link, external
// - count on rising or falling edge
// - clear source: off, frame, exposure, acquisition, external
// - edge clear on rising, falling or either edge of frame, exposure or external
// - level clear holds zero while source high or low
// - software clear zeroes count; restarts if start source off, else back to idle
// - count readable without disturbing counting
// - each clear captures the prior count
// - terminal count 1..4294967295 stops counting
// - state reads idle, active or done
// - start source: off, frame, exposure, acquisition, external
// - edge start on rising, falling or either edge of frame, exposure or external
// - level start holds count reset at chosen level
// - pulse width 1..4294967295 us in edge modes
// - delay 0..4294967295 us before output
// - timer clear returns to idle, re-armed
// - timer trigger: off, exposure, frame, external, tally start
// - edge trigger on rising or falling edge
// - level mode: output only while source at level
// - level-high: delay, then output follows source
// - timer output routed to output line
// - exposure pulse spans each exposure
// - external trigger debounced
`timescale 1ns/1ps
`default_nettype none
`include "event_timer_defines.vh"
module event_counter_and_delay_timer #(
    parameter WIDTH = 32
) (
    // clock and reset
    input  wire        clk_sys,
    input  wire        rst,
    // avalon-mm slave
    input  wire [5:0]  avsAddress,
    input  wire        avsRead,
    input  wire        avsWrite,
    input  wire [31:0] avsWriteData,
    input  wire [3:0]  avsByteEnable,
    output reg  [31:0] avsReadData,
    output reg         avsWaitRequest,
    // camera timing sources
    input  wire        frameReadoutPulse,
    input  wire        rowTimePulse,
    input  wire        exposureWindowPulse,
    input  wire        acquisitionWindowSignal,
    input  wire        hostLinkTrigger,
    input  wire        externalTriggerInput,
    // outputs
    output reg         pulseUnitOutput,
    output reg         outputLine,
    output reg         tallyStartIndication
);
    // ==========
    // functions
    function selSrc;
        input [2:0] code;
        input [7:0] v;
        begin
            selSrc = v[code];
        end
    endfunction

    function condHit;
        input [2:0] cond;
        input       rise;
        input       fall;
        input       lvl;
        begin
            case (cond)
                `COND_EDGE_UP:    condHit = rise;
                `COND_EDGE_DOWN:  condHit = fall;
                `COND_EDGE_EITHR: condHit = rise | fall;
                `COND_LEVEL_UP:   condHit = lvl;
                `COND_LEVEL_DOWN: condHit = ~lvl;
                default:          condHit = 1'b0;
            endcase
        end
    endfunction

    // ==========
    // registers
    reg [31:0] ctrl_reg;
    reg [31:0] terminal_reg;
    reg [31:0] delay_reg;
    reg [31:0] width_reg;
    reg [31:0] debounce_reg;
    reg        tallyClrCmd_reg;
    reg        pulseClrCmd_reg;
    reg        busy_reg;

    wire [2:0] tallySrcSel  = ctrl_reg[`CF_SRC_LO+2:`CF_SRC_LO];
    wire       tallyEdgePol = ctrl_reg[`CF_POL];
    wire [2:0] clrSrcSel    = ctrl_reg[`CF_CLR_SRC_LO+2:`CF_CLR_SRC_LO];
    wire [2:0] clrCond      = ctrl_reg[`CF_CLR_COND_LO+2:`CF_CLR_COND_LO];
    wire [2:0] startSrcSel  = ctrl_reg[`CF_START_SRC_LO+2:`CF_START_SRC_LO];
    wire [2:0] startCond    = ctrl_reg[`CF_START_CND_LO+2:`CF_START_CND_LO];
    wire [2:0] ptSrcSel     = ctrl_reg[`CF_PT_SRC_LO+2:`CF_PT_SRC_LO];
    wire [2:0] ptCond       = ctrl_reg[`CF_PT_CND_LO+2:`CF_PT_CND_LO];
    wire       lineSel      = ctrl_reg[`CF_LINE_SEL];

    // ==========
    // synchronisers
    localparam NSRC = 6;
    wire [NSRC-1:0] rawIn = {externalTriggerInput, hostLinkTrigger, acquisitionWindowSignal,
                             exposureWindowPulse, rowTimePulse, frameReadoutPulse};
    reg  [NSRC-1:0] sync1_reg;
    reg  [NSRC-1:0] sync2_reg;
    always @(posedge clk_sys)
    begin
        if (rst)
        begin
            sync1_reg <= 6'h00;
            sync2_reg <= 6'h00;
        end
        else
        begin
            sync1_reg <= rawIn;
            sync2_reg <= sync1_reg;
        end
    end

    // ==========
    // 1 us time base
    localparam [4:0] US_CYC = `CYC_PER_US;
    reg [4:0] usDiv_reg;
    reg       usTick_reg;
    always @(posedge clk_sys)
    begin
        if (rst)
        begin
            usDiv_reg  <= 5'h00;
            usTick_reg <= 1'b0;
        end
        else
        begin
            usTick_reg <= (usDiv_reg == US_CYC - 5'h01);
            usDiv_reg  <= (usDiv_reg == US_CYC - 5'h01) ? 5'h00 : usDiv_reg + 5'h01;
        end
    end

    // ==========
    // external trigger debounce
    reg        extClean_reg;
    reg [31:0] dbCnt_reg;
    always @(posedge clk_sys)
    begin
        if (rst)
        begin
            extClean_reg <= 1'b0;
            dbCnt_reg    <= 32'h0000_0000;
        end
        else if (sync2_reg[5] == extClean_reg)
            dbCnt_reg <= 32'h0000_0000;
        else if (dbCnt_reg >= debounce_reg)
        begin
            extClean_reg <= sync2_reg[5];
            dbCnt_reg    <= 32'h0000_0000;
        end
        else if (usTick_reg)
            dbCnt_reg <= dbCnt_reg + 32'h0000_0001;
    end

    // ==========
    // levels and edges
    wire [7:0] lvlNow = {tallyStartIndication, sync2_reg[2], extClean_reg, sync2_reg[4],
                         sync2_reg[2], sync2_reg[1], sync2_reg[0], 1'b0};
    reg  [7:0] lvlPrev_reg;
    always @(posedge clk_sys)
    begin
        if (rst)
            lvlPrev_reg <= 8'h00;
        else
            lvlPrev_reg <= lvlNow;
    end
    wire [7:0] riseV = lvlNow & ~lvlPrev_reg;
    wire [7:0] fallV = ~lvlNow & lvlPrev_reg;
    // index 6 = acquisition window, 7 = constant zero
    wire [7:0] lvlClr = {1'b0, sync2_reg[3], lvlNow[5:0]};
    wire [7:0] rClr   = lvlClr & ~{1'b0, lvlPrev_reg[6], lvlPrev_reg[5:0]};
    wire [7:0] fClr   = ~lvlClr & {1'b0, lvlPrev_reg[6], lvlPrev_reg[5:0]};

    // ==========
    // tally unit
    localparam [1:0] T_IDLE = `TS_IDLE;
    localparam [1:0] T_ACT  = `TS_ACTIVE;
    localparam [1:0] T_DONE = `TS_DONE;
    reg [WIDTH-1:0] tallyCurrent_reg;
    reg [WIDTH-1:0] tallyCaptured_reg;
    reg [1:0]       tallyState_reg;

    wire cntEvt   = (tallySrcSel != `SRC_OFF) && (tallySrcSel <= `SRC_EXT) &&
                    (tallyEdgePol ? selSrc(tallySrcSel, fallV) : selSrc(tallySrcSel, riseV));
    wire clrValid = (clrSrcSel == `SRC_FRAME) || (clrSrcSel == `SRC_EXPO) ||
                    (clrSrcSel == `SRC_ACQ) || (clrSrcSel == `SRC_EXT);
    wire clrHit   = clrValid && condHit(clrCond, selSrc(clrSrcSel, rClr),
                    selSrc(clrSrcSel, fClr), selSrc(clrSrcSel, lvlClr));
    wire stValid  = (startSrcSel == `SRC_FRAME) || (startSrcSel == `SRC_EXPO) ||
                    (startSrcSel == `SRC_ACQ) || (startSrcSel == `SRC_EXT);
    wire stLevel  = (startCond == `COND_LEVEL_UP) || (startCond == `COND_LEVEL_DOWN);
    wire stHit    = stValid && condHit(startCond, selSrc(startSrcSel, rClr),
                    selSrc(startSrcSel, fClr), selSrc(startSrcSel, lvlClr));
    wire anyClr   = clrHit || tallyClrCmd_reg || (stHit && stLevel);

    always @(posedge clk_sys)
    begin
        if (rst)
        begin
            tallyCurrent_reg     <= 32'h0000_0000;
            tallyCaptured_reg    <= 32'h0000_0000;
            tallyState_reg       <= T_IDLE;
            tallyStartIndication <= 1'b0;
        end
        else
        begin
            tallyStartIndication <= 1'b0;
            if (anyClr)
            begin
                tallyCaptured_reg <= tallyCurrent_reg;
                tallyCurrent_reg  <= 32'h0000_0000;
                if (tallyClrCmd_reg && !stValid)
                begin
                    tallyState_reg       <= T_ACT;
                    tallyStartIndication <= 1'b1;
                end
                else
                    tallyState_reg <= stValid ? T_IDLE : T_ACT;
            end
            else
            begin
                case (tallyState_reg)
                    T_IDLE:
                    begin
                        if (!stValid || (stHit && !stLevel))
                        begin
                            tallyState_reg       <= T_ACT;
                            tallyStartIndication <= 1'b1;
                        end
                    end
                    T_ACT:
                    begin
                        if (cntEvt)
                        begin
                            tallyCurrent_reg <= tallyCurrent_reg + 32'h0000_0001;
                            if (tallyCurrent_reg + 32'h0000_0001 >= terminal_reg)
                                tallyState_reg <= T_DONE;
                        end
                    end
                    T_DONE:
                        tallyState_reg <= T_DONE;
                    default:
                        tallyState_reg <= T_IDLE;
                endcase
            end
        end
    end

    // ==========
    // pulse unit
    localparam [3:0] P_IDLE  = 4'h1;
    localparam [3:0] P_DELAY = 4'h2;
    localparam [3:0] P_HIGH  = 4'h4;
    localparam [3:0] P_WAIT  = 4'h8;
    reg [3:0]  pState_reg;
    reg [31:0] pCnt_reg;
    wire ptValid = (ptSrcSel == `SRC_EXPO) || (ptSrcSel == `SRC_FRAME) ||
                   (ptSrcSel == `SRC_EXT) || (ptSrcSel == `SRC_TALLYSTART);
    wire ptLevelMode = (ptCond == `COND_LEVEL_UP) || (ptCond == `COND_LEVEL_DOWN);
    wire ptActive = ptValid && condHit(ptCond, selSrc(ptSrcSel, riseV),
                    selSrc(ptSrcSel, fallV), selSrc(ptSrcSel, lvlNow));

    always @(posedge clk_sys)
    begin
        if (rst || pulseClrCmd_reg)
        begin
            pState_reg      <= P_IDLE;
            pCnt_reg        <= 32'h0000_0000;
            pulseUnitOutput <= 1'b0;
        end
        else
        begin
            case (pState_reg)
                P_IDLE:
                begin
                    pulseUnitOutput <= 1'b0;
                    pCnt_reg        <= 32'h0000_0000;
                    if (ptActive && ptCond != `COND_EDGE_EITHR)
                        pState_reg <= P_DELAY;
                end
                P_DELAY:
                begin
                    if (ptLevelMode && !ptActive)
                        pState_reg <= P_IDLE;
                    else if (pCnt_reg >= delay_reg)
                    begin
                        pCnt_reg        <= 32'h0000_0000;
                        pulseUnitOutput <= 1'b1;
                        pState_reg      <= P_HIGH;
                    end
                    else if (usTick_reg)
                        pCnt_reg <= pCnt_reg + 32'h0000_0001;
                end
                P_HIGH:
                begin
                    if (ptLevelMode ? !ptActive : (pCnt_reg + 32'h0000_0001 >= width_reg) &&
                        usTick_reg)
                    begin
                        pulseUnitOutput <= 1'b0;
                        pState_reg      <= ptLevelMode ? P_IDLE : P_WAIT;
                    end
                    else if (usTick_reg)
                        pCnt_reg <= pCnt_reg + 32'h0000_0001;
                end
                P_WAIT:
                    pState_reg <= P_IDLE;
                default:
                    pState_reg <= P_IDLE;
            endcase
        end
    end

    always @(posedge clk_sys)
    begin
        if (rst)
            outputLine <= 1'b0;
        else
            outputLine <= lineSel & pulseUnitOutput;
    end

    // ==========
    // avalon-mm slave, one wait cycle
    wire [3:0] wordIdx = avsAddress[5:2];
    wire       take    = (avsRead | avsWrite) & busy_reg;
    always @(posedge clk_sys)
    begin
        if (rst)
        begin
            ctrl_reg        <= `RST_CTRL;
            terminal_reg    <= `RST_TERMINAL;
            delay_reg       <= 32'h0000_0000;
            width_reg       <= 32'h0000_0001;
            debounce_reg    <= 32'h0000_0000;
            tallyClrCmd_reg <= 1'b0;
            pulseClrCmd_reg <= 1'b0;
            busy_reg        <= 1'b0;
            avsWaitRequest  <= 1'b1;
            avsReadData     <= 32'h0000_0000;
        end
        else
        begin
            tallyClrCmd_reg <= 1'b0;
            pulseClrCmd_reg <= 1'b0;
            busy_reg        <= (avsRead | avsWrite) & ~busy_reg;
            avsWaitRequest  <= ~((avsRead | avsWrite) & ~busy_reg);
            if (take && avsWrite && avsByteEnable == 4'hf)
            begin
                case (wordIdx)
                    `ADR_CTRL:     ctrl_reg <= avsWriteData;
                    `ADR_CMD:
                    begin
                        tallyClrCmd_reg <= avsWriteData[0];
                        pulseClrCmd_reg <= avsWriteData[1];
                    end
                    `ADR_TERMINAL: terminal_reg <= (avsWriteData == 32'h0) ? 32'h1 : avsWriteData;
                    `ADR_PDELAY:   delay_reg <= avsWriteData;
                    `ADR_PWIDTH:   width_reg <= (avsWriteData == 32'h0) ? 32'h1 : avsWriteData;
                    `ADR_DEBOUNCE: debounce_reg <= avsWriteData;
                    default:       ctrl_reg <= ctrl_reg;
                endcase
            end
            if ((avsRead | avsWrite) & ~busy_reg)
            begin
                case (wordIdx)
                    `ADR_CTRL:     avsReadData <= ctrl_reg;
                    `ADR_TERMINAL: avsReadData <= terminal_reg;
                    `ADR_CURRENT:  avsReadData <= tallyCurrent_reg;
                    `ADR_CAPTURED: avsReadData <= tallyCaptured_reg;
                    `ADR_STATE:    avsReadData <= {26'h0, pState_reg, tallyState_reg};
                    `ADR_PDELAY:   avsReadData <= delay_reg;
                    `ADR_PWIDTH:   avsReadData <= width_reg;
                    `ADR_DEBOUNCE: avsReadData <= debounce_reg;
                    default:       avsReadData <= 32'h0000_0000;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// [rtl/event_timer_defines.vh]
`ifndef EVENT_TIMER_DEFINES_VH
`define EVENT_TIMER_DEFINES_VH
// ==========
// register word indexes
`define ADR_CTRL        4'h0
`define ADR_CMD         4'h1
`define ADR_TERMINAL    4'h2
`define ADR_CURRENT     4'h3
`define ADR_CAPTURED    4'h4
`define ADR_STATE       4'h5
`define ADR_PDELAY      4'h6
`define ADR_PWIDTH      4'h7
`define ADR_DEBOUNCE    4'h8
// ==========
// control field positions
`define CF_SRC_LO       0
`define CF_POL          3
`define CF_CLR_SRC_LO   4
`define CF_CLR_COND_LO  7
`define CF_START_SRC_LO 10
`define CF_START_CND_LO 13
`define CF_PT_SRC_LO    16
`define CF_PT_CND_LO    19
`define CF_LINE_SEL     22
// ==========
// source codes
`define SRC_OFF         3'h0
`define SRC_FRAME       3'h1
`define SRC_ROW         3'h2
`define SRC_EXPO        3'h3
`define SRC_HOSTLINK    3'h4
`define SRC_EXT         3'h5
`define SRC_ACQ         3'h6
`define SRC_TALLYSTART  3'h7
// condition codes
`define COND_EDGE_UP    3'h0
`define COND_EDGE_DOWN  3'h1
`define COND_EDGE_EITHR 3'h2
`define COND_LEVEL_UP   3'h3
`define COND_LEVEL_DOWN 3'h4
// tally state codes
`define TS_IDLE         2'h0
`define TS_ACTIVE       2'h1
`define TS_DONE         2'h2
// reset values
`define RST_CTRL        32'h0000_0000
`define RST_TERMINAL    32'hffff_ffff
// timing
`define CYC_PER_US      5'h14
`endif

// [bench/event_timer_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
`include "event_timer_defines.vh"
module event_timer_assertions (
    // clock and reset
    input wire logic        clk_sys,
    input wire logic        rst,
    // register bus
    input wire logic [5:0]  avsAddress,
    input wire logic        avsRead,
    input wire logic        avsWrite,
    input wire logic [31:0] avsWriteData,
    input wire logic [3:0]  avsByteEnable,
    input wire logic [31:0] avsReadData,
    input wire logic        avsWaitRequest,
    // outputs
    input wire logic        pulseUnitOutput,
    input wire logic        outputLine,
    input wire logic        tallyStartIndication
);
    // ==========
    // shadows
    logic lineSel_reg;
    logic timerClr_reg;
    wire  req    = avsRead || avsWrite;
    wire  wrDone = avsWrite && !avsWaitRequest && avsByteEnable == 4'hf;
    always @(posedge clk_sys)
    begin
        if (rst)
        begin
            lineSel_reg  <= 1'h0;
            timerClr_reg <= 1'h0;
        end
        else
        begin
            if (wrDone && avsAddress[5:2] == `ADR_CTRL)
                lineSel_reg <= avsWriteData[`CF_LINE_SEL];
            timerClr_reg <= wrDone && avsAddress[5:2] == `ADR_CMD && avsWriteData[1];
        end
    end
    // ==========
    // properties
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    AST_ANSWER_NEXT:
        assert property (req && avsWaitRequest |=> !avsWaitRequest)
        else $error("request not answered");
    AST_ANSWER_ONE:
        assert property (!avsWaitRequest |=> avsWaitRequest)
        else $error("answer longer than one cycle");
    AST_QUIET_IDLE:
        assert property (!req |=> avsWaitRequest)
        else $error("answer without request");
    AST_READ_STABLE:
        assert property (avsWaitRequest && $past(avsWaitRequest) |-> $stable(avsReadData))
        else $error("read data moved while idle");
    AST_LINE_FOLLOW:
        assert property (lineSel_reg && $past(lineSel_reg) |-> outputLine == $past(pulseUnitOutput))
        else $error("line does not follow timer");
    AST_LINE_OFF:
        assert property (!lineSel_reg && !$past(lineSel_reg) |-> !outputLine)
        else $error("line driven while not selected");
    AST_START_PULSE:
        assert property (tallyStartIndication |=> !tallyStartIndication)
        else $error("start indication too long");
    AST_TIMER_CLEAR:
        assert property (timerClr_reg |-> ##[0:2] !pulseUnitOutput)
        else $error("timer output kept after clear");
    cover property ($rose(pulseUnitOutput));
    cover property (tallyStartIndication);
    cover property (avsRead && !avsWaitRequest);
endmodule
bind event_counter_and_delay_timer event_timer_assertions chk (
    .clk_sys(clk_sys), .rst(rst), .avsAddress(avsAddress), .avsRead(avsRead),
    .avsWrite(avsWrite), .avsWriteData(avsWriteData), .avsByteEnable(avsByteEnable),
    .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest),
    .pulseUnitOutput(pulseUnitOutput), .outputLine(outputLine),
    .tallyStartIndication(tallyStartIndication)
);
`default_nettype wire

// [bench/camera_timing_model.sv]
`timescale 1ns/1ps
`default_nettype none
module camera_timing_model #(
    parameter int HOLD = 30
) (
    // clock
    input  wire logic       clk_sys,
    // requests: frame, row, exposure, acquisition, host link, external
    input  wire logic [5:0] fire,
    input  wire logic [5:0] levelReq,
    // source levels
    output logic [5:0]      src
);
    // ==========
    // pulse stretchers
    int         left [6];
    logic [5:0] busy;
    always @(posedge clk_sys)
    begin
        for (int i = 0; i < 6; i++)
        begin
            if (fire[i])
                left[i] <= HOLD;
            else if (left[i] > 0)
                left[i] <= left[i] - 1;
        end
    end
    always_comb
    begin
        for (int i = 0; i < 6; i++)
            busy[i] = left[i] > 0;
    end
    // windows held past debounce
    assign src = levelReq | busy;
endmodule
`default_nettype wire

// [bench/test_event_counter_and_delay_timer.sv]
`timescale 1ns/1ps
`default_nettype none
`include "event_timer_defines.vh"
module test_event_counter_and_delay_timer;
    localparam int          HOLD = 30;
    localparam logic [31:0] ALL  = 32'hffff_ffff;
    // ==========
    // signals
    logic        clk_sys = 1'h0;
    logic        rst = 1'h1;
    logic [5:0]  avsAddress = 6'h00;
    logic        avsRead = 1'h0;
    logic        avsWrite = 1'h0;
    logic [31:0] avsWriteData = 32'h0;
    logic [3:0]  avsByteEnable = 4'hf;
    logic [31:0] avsReadData;
    logic        avsWaitRequest;
    logic [5:0]  fire = 6'h00;
    logic [5:0]  levelReq = 6'h00;
    logic [5:0]  src;
    logic        pulseUnitOutput;
    logic        outputLine;
    logic        tallyStartIndication;
    logic        m;
    int          err_total = 0;
    int          samples_checked = 0;
    int          seed = 83;
    int          cycles = 0;
    int          starts = 0;
    int          n, t, w;
    logic [31:0] expQ [$];
    logic [31:0] maskQ [$];
    string       nameQ [$];
    int          cnt [6] = '{1, 2, 3, 4, 5, 0};
    int          pin [6] = '{0, 1, 2, 4, 5, 0};
    int          tsrc [4] = '{3, 1, 5, 7};
    int          tpin [4] = '{2, 0, 5, 2};
    int          tt [4][7] = '{'{0, 150, 20, 70, 40, 80, 0}, '{1, 100, 115, 175, 40, 80, 0},
                               '{3, 150, 20, 70, 75, 140, 1}, '{4, 150, 0, 300, 0, 300, 0}};
    initial forever #25 clk_sys = ~clk_sys;
    event_counter_and_delay_timer dut (
        .clk_sys(clk_sys), .rst(rst), .avsAddress(avsAddress), .avsRead(avsRead),
        .avsWrite(avsWrite), .avsWriteData(avsWriteData), .avsByteEnable(avsByteEnable),
        .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest),
        .frameReadoutPulse(src[0]), .rowTimePulse(src[1]), .exposureWindowPulse(src[2]),
        .acquisitionWindowSignal(src[3]), .hostLinkTrigger(src[4]),
        .externalTriggerInput(src[5]), .pulseUnitOutput(pulseUnitOutput),
        .outputLine(outputLine), .tallyStartIndication(tallyStartIndication)
    );
    camera_timing_model #(.HOLD(HOLD)) far (
        .clk_sys(clk_sys), .fire(fire), .levelReq(levelReq), .src(src)
    );
    // ==========
    // tasks
    task automatic check(input string s, input logic [31:0] seen, input logic [31:0] e);
        samples_checked++;
        if (seen !== e)
        begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", s, e, seen);
        end
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic waitAck;
        do @(posedge clk_sys); while (avsWaitRequest !== 1'h0);
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] be = 4'hf);
        @(posedge clk_sys);
        avsAddress <= {a, 2'h0};
        avsWriteData <= d;
        avsByteEnable <= be;
        avsWrite <= 1'h1;
        waitAck();
        avsWrite <= 1'h0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] k,
                      input string s);
        expQ.push_back(e & k);
        maskQ.push_back(k);
        nameQ.push_back(s);
        @(posedge clk_sys);
        avsAddress <= {a, 2'h0};
        avsRead <= 1'h1;
        waitAck();
        avsRead <= 1'h0;
    endtask
    function automatic logic [31:0] cf(input int s, p, cs, cc, ss, sc, ts, tc, ln);
        cf = {9'h0, ln[0], tc[2:0], ts[2:0], sc[2:0], ss[2:0], cc[2:0], cs[2:0], p[0], s[2:0]};
    endfunction
    task automatic pulse(input int i);
        @(posedge clk_sys);
        fire[i] <= 1'h1;
        @(posedge clk_sys);
        fire[i] <= 1'h0;
    endtask
    task automatic ev(input int i, input int k);
        repeat (k)
        begin
            pulse(i);
            repeat (2 * HOLD) @(posedge clk_sys);
        end
    endtask
    task automatic lvl(input int i, input logic v);
        @(posedge clk_sys);
        levelReq[i] <= v;
        repeat (HOLD) @(posedge clk_sys);
    endtask
    task automatic watch(input int i, input int k);
        w = 0;
        if (i >= 0)
            pulse(i);
        repeat (k)
        begin
            @(posedge clk_sys);
            w += (pulseUnitOutput === 1'h1);
        end
    endtask
    task automatic run(input int hold);
        t = 0;
        w = 0;
        for (int k = 0; k < 300; k++)
        begin
            @(posedge clk_sys);
            levelReq[0] <= (k < hold);
            if (k == hold - 10)
                m = pulseUnitOutput;
            if (pulseUnitOutput === 1'h1)
            begin
                if (w == 0)
                    t = k;
                w++;
            end
        end
    endtask
    task automatic done(input string s);
        $display("test %s finished", s);
    endtask
    // ==========
    // result watcher and timeout
    always @(posedge clk_sys)
    begin
        cycles++;
        if (tallyStartIndication === 1'h1)
            starts++;
        if (avsRead && avsWaitRequest === 1'h0)
            check(nameQ.pop_front(), avsReadData & maskQ.pop_front(), expQ.pop_front());
        if (cycles == 40000)
        begin
            err_total++;
            stop_test();
        end
    end
    // ==========
    // scenarios
    initial
    begin
        repeat (6) @(posedge clk_sys);
        rst <= 1'h0;
        rd(`ADR_CTRL, `RST_CTRL, ALL, "ctrl");
        rd(`ADR_PWIDTH, 32'h1, ALL, "width");
        wr(`ADR_TERMINAL, 32'h5, 4'h3);
        rd(`ADR_TERMINAL, `RST_TERMINAL, ALL, "terminal");
        wr(4'hf, 32'h5);
        rd(4'hf, 32'h0, ALL, "unmapped");
        wr(`ADR_DEBOUNCE, 32'h0);
        done("registers");
        for (int k = 0; k < 6; k++)
        begin
            n = 1 + ($random(seed) & 3);
            wr(`ADR_CTRL, cf(cnt[k], 0, 0, 0, 0, 0, 0, 0, 0));
            wr(`ADR_CMD, 32'h1);
            ev(pin[k], n);
            ev(pin[(k + 1) % 5], 1);
            ev(3, 1);
            rd(`ADR_CURRENT, k < 5 ? n : 0, ALL, "count");
            rd(`ADR_STATE, `TS_ACTIVE, 32'h3, "state");
        end
        for (int p = 0; p < 2; p++)
        begin
            wr(`ADR_CTRL, cf(1, p, 0, 0, 0, 0, 0, 0, 0));
            wr(`ADR_CMD, 32'h1);
            lvl(0, 1'h1);
            rd(`ADR_CURRENT, p == 0, ALL, "after rise");
            lvl(0, 1'h0);
            rd(`ADR_CURRENT, 32'h1, ALL, "after fall");
        end
        done("count sources");
        wr(`ADR_TERMINAL, 32'h1);
        wr(`ADR_CMD, 32'h1);
        ev(0, 3);
        rd(`ADR_CURRENT, 32'h1, ALL, "terminal stop");
        rd(`ADR_STATE, `TS_DONE, 32'h3, "done");
        wr(`ADR_CMD, 32'h1);
        rd(`ADR_CAPTURED, 32'h1, ALL, "captured");
        rd(`ADR_CURRENT, 32'h0, ALL, "cleared");
        wr(`ADR_TERMINAL, ALL);
        for (int c = 0; c < 3; c++)
        begin
            wr(`ADR_CTRL, cf(2, 0, 1, c, 0, 0, 0, 0, 0));
            wr(`ADR_CMD, 32'h1);
            ev(1, 2);
            lvl(0, 1'h1);
            ev(1, 1);
            rd(`ADR_CURRENT, c == 1 ? 3 : 1, ALL, "edge clear");
            lvl(0, 1'h0);
            rd(`ADR_CURRENT, c == 0 ? 1 : 0, ALL, "edge clear");
            rd(`ADR_CAPTURED, c == 0 ? 2 : (c == 1 ? 3 : 1), ALL, "capture");
        end
        for (int c = 3; c < 5; c++)
        begin
            wr(`ADR_CTRL, cf(2, 0, 6, c, 0, 0, 0, 0, 0));
            wr(`ADR_CMD, 32'h1);
            lvl(3, c == 3);
            ev(1, 2);
            rd(`ADR_CURRENT, 32'h0, ALL, "held clear");
            lvl(3, c == 4);
            ev(1, 1);
            rd(`ADR_CURRENT, 32'h1, ALL, "released");
        end
        lvl(3, 1'h0);
        done("clear");
        wr(`ADR_CTRL, cf(2, 0, 0, 0, 3, 0, 0, 0, 0));
        wr(`ADR_CMD, 32'h1);
        ev(1, 1);
        rd(`ADR_STATE, `TS_IDLE, 32'h3, "waiting");
        starts = 0;
        ev(2, 1);
        ev(1, 2);
        rd(`ADR_CURRENT, 32'h2, ALL, "started");
        check("start pulse", starts, 1);
        wr(`ADR_CTRL, cf(2, 0, 0, 0, 6, 3, 0, 0, 0));
        lvl(3, 1'h1);
        ev(1, 2);
        rd(`ADR_CURRENT, 32'h0, ALL, "start level");
        lvl(3, 1'h0);
        done("start");
        wr(`ADR_PDELAY, 32'h2);
        wr(`ADR_PWIDTH, 32'h3);
        for (int k = 0; k < 4; k++)
        begin
            wr(`ADR_CTRL, cf(0, 0, 0, 0, 0, 0, 1, tt[k][0], 1));
            wr(`ADR_CMD, 32'h2);
            run(tt[k][1]);
            check("rise time", t >= tt[k][2] && t <= tt[k][3], 1);
            check("high time", w >= tt[k][4] && w <= tt[k][5], 1);
            check("mid level", m, tt[k][6]);
        end
        wr(`ADR_PDELAY, 32'h0);
        wr(`ADR_PWIDTH, 32'h2);
        for (int k = 0; k < 4; k++)
        begin
            wr(`ADR_CTRL, cf(0, 0, 0, 0, 3, 0, tsrc[k], 0, 1));
            wr(`ADR_CMD, 32'h3);
            watch(3, 100);
            check("unselected", w, 0);
            watch(tpin[k], 100);
            check("selected", w >= 20 && w <= 60, 1);
        end
        wr(`ADR_PDELAY, 32'h5);
        wr(`ADR_CTRL, cf(0, 0, 0, 0, 0, 0, 1, 0, 1));
        pulse(0);
        repeat (30) @(posedge clk_sys);
        wr(`ADR_CMD, 32'h2);
        watch(-1, 200);
        check("after timer clear", w, 0);
        watch(0, 250);
        check("re-armed", w >= 20 && w <= 60, 1);
        done("timer");
        @(posedge clk_sys);
        stop_test();
    end
endmodule
`default_nettype wire
